// >>> core/scm_i2c_link.sv
// I2C slave running on the serial clock, hands register requests across
`timescale 1ns/10ps
module scm_i2c_link import scm_pkg::*; (
	input logic scl_clk,
	input logic reset,
	input logic sda_in,
	input logic [2:0] addr_pin,
	output logic sda_out,
	output logic sda_oe,
	scm_reg_if.link bus
);
	logic rst_meta_reg, rst_sync_reg;
	logic [2:0] addr_meta_reg, addr_sync_reg;
	logic ack_meta_reg, ack_sync_reg;
	logic sda_pos_reg;
	logic start_flag_reg, start_hit_reg;
	scm_i2c_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic rw_reg, rw_next, oe_reg, oe_next;
	logic wr_reg, wr_next, req_reg, req_next;
	logic [7:0] byte_in;
	logic [7:0] load_byte;

	// Open drain: the line is only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;
	assign bus.req_tog = req_reg;
	assign bus.is_wr = wr_reg;
	assign bus.ptr = ptr_reg;
	assign bus.wdata = wdata_reg;
	assign byte_in = {shift_reg[6:0], sda_pos_reg};
	// Read data is only trusted once the register side has answered
	assign load_byte = (ack_sync_reg == req_reg) ? bus.rdata : RD_FILL;

	always_ff @(posedge scl_clk) begin
		sda_pos_reg <= sda_in;
	end

	// Start seen as data falling while the clock is high; cleared from the clock side
	always_ff @(negedge sda_in or posedge start_hit_reg or posedge rst_sync_reg) begin
		if (start_hit_reg | rst_sync_reg) begin
			start_flag_reg <= 1'b0;
		end else if (scl_clk) begin
			start_flag_reg <= 1'b1;
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		wdata_next = wdata_reg;
		rw_next = rw_reg;
		wr_next = wr_reg;
		req_next = req_reg;
		oe_next = 1'b0;
		if (start_flag_reg) begin
			state_next = ST_ADDR;
			cnt_next = '0;
		end else begin
			case (state_reg)
				ST_ADDR: begin
					shift_next = byte_in;
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == BIT_LAST) begin
						if (byte_in[7:1] == {I2C_ADDR_HI, addr_sync_reg}) begin
							state_next = ST_ADDR_ACK;
							rw_next = byte_in[0];
							oe_next = 1'b1;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					cnt_next = '0;
					if (rw_reg) begin
						state_next = ST_RDATA;
						shift_next = load_byte;
						oe_next = ~load_byte[7];
					end else begin
						state_next = ST_PTR;
					end
				end
				ST_PTR, ST_WDATA: begin
					shift_next = byte_in;
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == BIT_LAST) begin
						oe_next = 1'b1;
						req_next = ~req_reg;
						wr_next = (state_reg == ST_WDATA);
						if (state_reg == ST_PTR) begin
							ptr_next = byte_in;
							state_next = ST_PTR_ACK;
						end else begin
							wdata_next = byte_in;
							state_next = ST_WDATA_ACK;
						end
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					cnt_next = '0;
					state_next = ST_WDATA;
				end
				ST_RDATA: begin
					cnt_next = cnt_reg + 3'h1;
					shift_next = {shift_reg[6:0], 1'b0};
					if (cnt_reg == BIT_LAST) begin
						state_next = ST_RDATA_ACK;
					end else begin
						oe_next = ~shift_reg[6];
					end
				end
				ST_RDATA_ACK: begin
					cnt_next = '0;
					if (!sda_pos_reg) begin
						state_next = ST_RDATA;
						shift_next = load_byte;
						oe_next = ~load_byte[7];
					end else begin
						state_next = ST_IDLE;
					end
				end
				default: state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(negedge scl_clk) begin
		rst_meta_reg <= reset;
		rst_sync_reg <= rst_meta_reg;
		addr_meta_reg <= addr_pin;
		addr_sync_reg <= addr_meta_reg;
		ack_meta_reg <= bus.ack_tog;
		ack_sync_reg <= ack_meta_reg;
		start_hit_reg <= start_flag_reg;
		if (rst_sync_reg) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			shift_reg <= '0;
			ptr_reg <= '0;
			wdata_reg <= '0;
			rw_reg <= 1'b0;
			wr_reg <= 1'b0;
			req_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			wdata_reg <= wdata_next;
			rw_reg <= rw_next;
			wr_reg <= wr_next;
			req_reg <= req_next;
			oe_reg <= oe_next;
		end
	end
endmodule : scm_i2c_link

// >>> core/scm_switch_ctrl.sv
// Control-source selection and register file of the buffered mux/demux switch
`timescale 1ns/10ps
module scm_switch_ctrl import scm_pkg::*; (
	input logic sys_clk,
	input logic reset,
	input logic scl_clk,
	input logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input logic [2:0] i2c_addr_pin,
	input logic reset_pin_n,
	input logic bicast_pin,
	input logic lane0_path_select,
	input logic lane1_path_select,
	input logic port_a_loop_pin,
	input logic port_b_loop_pin,
	input logic port_c_loop_pin,
	input logic port_a_rx_boost_pin,
	input logic port_b_rx_boost_pin,
	input logic port_c_rx_boost_pin,
	input logic port_a_tx_emphasis_pin,
	input logic port_b_tx_emphasis_pin,
	input logic port_c_tx_emphasis_pin,
	input logic [NUM_PORTS-1:0] los_detect,
	output logic [1:0] active_mode,
	output logic bicast_en,
	output logic [NUM_LANES-1:0] lane_sel,
	output logic [NUM_PORTS-1:0] loop_en,
	output logic [NUM_PORTS-1:0][3:0] rx_eq_level,
	output logic [NUM_PORTS-1:0][2:0] tx_pe_level,
	output logic [NUM_LANES-1:0][1:0] port_a_src,
	output logic [NUM_LANES-1:0][1:0] port_b_src,
	output logic [NUM_LANES-1:0][1:0] port_c_src,
	output logic signal_lost_irq
);
	scm_reg_if link_if ();

	scm_pins_t pins_raw;
	scm_pins_t pins_meta_reg;
	scm_pins_t pins_sync_reg;
	logic req_meta_reg;
	logic req_sync_reg;
	logic req_seen_reg;
	logic req_event;
	logic ack_reg, ack_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] rd_value;

	// Software-visible register state
	logic [1:0] mode_reg, mode_next;
	logic [NUM_PORTS-1:0] sw_loop_reg, sw_loop_next;
	logic sw_bicast_reg, sw_bicast_next;
	logic [NUM_LANES-1:0] sw_sel_reg, sw_sel_next;
	logic los_en_reg, los_en_next;
	logic [NUM_PORTS-1:0][3:0] eq_reg, eq_next;
	logic [NUM_PORTS-1:0][2:0] pe_reg, pe_next;

	// Values after the control-mode choice
	scm_mode_t mode_eff;
	logic sw_from_regs;
	logic set_from_regs;
	logic eff_bicast;
	logic [NUM_LANES-1:0] eff_sel;
	logic [NUM_PORTS-1:0] eff_loop;
	logic [NUM_PORTS-1:0][3:0] eff_eq;
	logic [NUM_PORTS-1:0][2:0] eff_pe;

	wire [NUM_LANES-1:0][1:0] a_src_w;
	wire [NUM_LANES-1:0][1:0] b_src_w;
	wire [NUM_LANES-1:0][1:0] c_src_w;

	// Output flops, so every port except the tied-low sda_out leaves straight from a register
	logic [1:0] mode_out_reg;
	logic bicast_out_reg;
	logic [NUM_LANES-1:0] sel_out_reg;
	logic [NUM_PORTS-1:0] loop_out_reg;
	logic [NUM_PORTS-1:0][3:0] eq_out_reg;
	logic [NUM_PORTS-1:0][2:0] pe_out_reg;
	logic [NUM_LANES-1:0][1:0] a_src_reg;
	logic [NUM_LANES-1:0][1:0] b_src_reg;
	logic [NUM_LANES-1:0][1:0] c_src_reg;
	logic irq_reg, irq_next;

	// Link runs on SCL, its start flag on SDA falling edges; the request toggle, pointer and data cross to the registers, and the answer crosses back
	scm_i2c_link u_link (
		.scl_clk(scl_clk),
		.reset(reset),
		.sda_in(sda_in),
		.addr_pin(i2c_addr_pin),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.bus(link_if.link)
	);

	// Answer side of the toggle handshake
	assign link_if.ack_tog = ack_reg;
	assign link_if.rdata = rdata_reg;

	// Every board pin is asynchronous to the system clock
	assign pins_raw.rst_n = reset_pin_n;
	assign pins_raw.bicast = bicast_pin;
	assign pins_raw.sel = {lane1_path_select, lane0_path_select};
	assign pins_raw.loop = {port_c_loop_pin, port_b_loop_pin, port_a_loop_pin};
	assign pins_raw.eq = {port_c_rx_boost_pin, port_b_rx_boost_pin, port_a_rx_boost_pin};
	assign pins_raw.pe = {port_c_tx_emphasis_pin, port_b_tx_emphasis_pin,
		port_a_tx_emphasis_pin};
	assign pins_raw.los = los_detect;

	// Two flops on every pin and on the request toggle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pins_meta_reg <= '0;
			pins_sync_reg <= '0;
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			req_seen_reg <= 1'b0;
		end else begin
			pins_meta_reg <= pins_raw;
			pins_sync_reg <= pins_meta_reg;
			req_meta_reg <= link_if.req_tog;
			req_sync_reg <= req_meta_reg;
			req_seen_reg <= req_sync_reg;
		end
	end

	// Pointer and data are held by the link long after the toggle moves
	assign req_event = req_sync_reg ^ req_seen_reg;

	always_comb begin
		rd_value = RD_UNMAPPED;
		case (link_if.ptr)
			REG_SWITCH: begin
				rd_value = (8'(sw_loop_reg) << LOOP_LSB) | (8'(sw_bicast_reg) << BICAST_BIT)
					| (8'(sw_sel_reg) << SEL_LSB);
			end
			REG_LOS_CFG: rd_value = 8'(los_en_reg);
			REG_STATUS: begin
				rd_value = 8'(pins_sync_reg.los) | (8'(mode_eff) << STAT_MODE_LSB);
			end
			REG_MODE: rd_value = 8'(mode_reg);
			default: rd_value = RD_UNMAPPED;
		endcase

		for (int p = 0; p < NUM_PORTS; p++) begin
			if (link_if.ptr == REG_EQ_A + 8'(p)) begin
				rd_value = 8'(eq_reg[p]);
			end
			if (link_if.ptr == REG_PE_A + 8'(p)) begin
				rd_value = 8'(pe_reg[p]);
			end
		end
	end

	always_comb begin
		ack_next = ack_reg;
		rdata_next = rdata_reg;
		mode_next = mode_reg;
		sw_loop_next = sw_loop_reg;
		sw_bicast_next = sw_bicast_reg;
		sw_sel_next = sw_sel_reg;
		los_en_next = los_en_reg;
		eq_next = eq_reg;
		pe_next = pe_reg;
		if (req_event) begin
			ack_next = ~ack_reg;
			rdata_next = rd_value;
			if (link_if.is_wr) begin
				case (link_if.ptr)
					REG_SWITCH: begin
						sw_loop_next = link_if.wdata[LOOP_LSB +: NUM_PORTS];
						sw_bicast_next = link_if.wdata[BICAST_BIT];
						sw_sel_next = link_if.wdata[SEL_LSB +: NUM_LANES];
					end
					REG_LOS_CFG: los_en_next = link_if.wdata[0];
					// Reserved bits are dropped, not stored
					REG_MODE: mode_next = link_if.wdata[1:0];
					default: mode_next = mode_reg;
				endcase
				for (int p = 0; p < NUM_PORTS; p++) begin
					if (link_if.ptr == REG_EQ_A + 8'(p)) begin
						// Codes past the last setting saturate
						eq_next[p] = (link_if.wdata[3:0] > EQ_MAX) ? EQ_MAX : link_if.wdata[3:0];
					end
					if (link_if.ptr == REG_PE_A + 8'(p)) begin
						pe_next[p] = link_if.wdata[2:0];
					end
				end
			end
		end

		// Placed last so the reset pin beats a write landing in the same cycle
		if (!pins_sync_reg.rst_n) begin
			mode_next = MODE_RST;
			sw_loop_next = '0;
			sw_bicast_next = 1'b0;
			sw_sel_next = '0;
			los_en_next = 1'b0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				eq_next[p] = EQ_RST;
				pe_next[p] = PE_RST;
			end
		end
	end

	// A plain reset starts in toggle-pin mode
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
			rdata_reg <= RD_UNMAPPED;
			mode_reg <= MODE_RST;
			sw_loop_reg <= '0;
			sw_bicast_reg <= 1'b0;
			sw_sel_reg <= '0;
			los_en_reg <= 1'b0;
			eq_reg <= '0;
			pe_reg <= '0;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			mode_reg <= mode_next;
			sw_loop_reg <= sw_loop_next;
			sw_bicast_reg <= sw_bicast_next;
			sw_sel_reg <= sw_sel_next;
			los_en_reg <= los_en_next;
			eq_reg <= eq_next;
			pe_reg <= pe_next;
		end
	end

	always_comb begin
		case (mode_reg)
			MODE_MIXED: mode_eff = MODE_MIXED;
			MODE_SERIAL: mode_eff = MODE_SERIAL;
			default: mode_eff = MODE_PIN;
		endcase

		sw_from_regs = (mode_eff == MODE_SERIAL);
		set_from_regs = (mode_eff != MODE_PIN);
		eff_bicast = sw_from_regs ? sw_bicast_reg : pins_sync_reg.bicast;
		eff_sel = sw_from_regs ? sw_sel_reg : pins_sync_reg.sel;
		eff_loop = sw_from_regs ? sw_loop_reg : pins_sync_reg.loop;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (set_from_regs) begin
				eff_eq[p] = eq_reg[p];
				eff_pe[p] = pe_reg[p];
			end else begin
				eff_eq[p] = pins_sync_reg.eq[p] ? EQ_PIN_HI : EQ_PIN_LO;
				eff_pe[p] = pins_sync_reg.pe[p] ? PE_PIN_HI : PE_PIN_LO;
			end
		end
		// Interrupt stays low until software has run the enable step
		irq_next = los_en_reg & (|pins_sync_reg.los);
	end

	// Loopback on a port overrides select and bicast for that port's outputs
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		assign a_src_w[l] = eff_loop[PORT_A] ? SRC_A
			: ((eff_bicast | ~eff_sel[l]) ? SRC_C : SRC_IDLE);
		assign b_src_w[l] = eff_loop[PORT_B] ? SRC_B
			: ((eff_bicast | eff_sel[l]) ? SRC_C : SRC_IDLE);
		assign c_src_w[l] = eff_loop[PORT_C] ? SRC_C
			: (eff_sel[l] ? SRC_B : SRC_A);
	end

	// Registered outputs; a pin change shows three edges later
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_out_reg <= MODE_RST;
			bicast_out_reg <= 1'b0;
			sel_out_reg <= '0;
			loop_out_reg <= '0;
			eq_out_reg <= '0;
			pe_out_reg <= '0;
			a_src_reg <= '0;
			b_src_reg <= '0;
			c_src_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			mode_out_reg <= mode_eff;
			bicast_out_reg <= eff_bicast;
			sel_out_reg <= eff_sel;
			loop_out_reg <= eff_loop;
			eq_out_reg <= eff_eq;
			pe_out_reg <= eff_pe;
			a_src_reg <= a_src_w;
			b_src_reg <= b_src_w;
			c_src_reg <= c_src_w;
			irq_reg <= irq_next;
		end
	end

	assign active_mode = mode_out_reg;
	assign bicast_en = bicast_out_reg;
	assign lane_sel = sel_out_reg;
	assign loop_en = loop_out_reg;
	assign rx_eq_level = eq_out_reg;
	assign tx_pe_level = pe_out_reg;
	assign port_a_src = a_src_reg;
	assign port_b_src = b_src_reg;
	assign port_c_src = c_src_reg;
	assign signal_lost_irq = irq_reg;
endmodule : scm_switch_ctrl

// >>> pkg/scm_pkg.sv
// Constants, types and register map of the switch control-source block
// Behaviour
// - Power-up starts in toggle-pin control mode
// - Reset pin low restores all registers
// - Mixed mode: switching still taken from pins
// - Mixed mode: registers override emphasis and equalizer
// - Serial mode: registers only, pins ignored
// - I2C slave only, address upper bits 1010
// - Address low bits from address pins
// - Mode 00 pin, 10 mixed, 11 serial
// - Registers give finer equalizer and emphasis choices
// - Loss interrupt active high after initialization
// - Bicast high duplicates data to A and B
// - Each lane has its own path select
// - Per-port loopback pin, high requests loopback
// - Per-port emphasis pin, high selects higher
// - Per-port equalizer pin selects pin level
// - Serial mode: register 0x01 bits 6:4 loopback
// - Mux to port C, demux from C
package scm_pkg;
	localparam int NUM_PORTS = 3;
	localparam int NUM_LANES = 2;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam logic [3:0] I2C_ADDR_HI = 4'ha;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] RD_FILL = 8'hff;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [7:0] REG_SWITCH = 8'h01;
	localparam logic [7:0] REG_LOS_CFG = 8'h02;
	localparam logic [7:0] REG_STATUS = 8'h03;
	localparam logic [7:0] REG_MODE = 8'h0f;
	localparam logic [7:0] REG_EQ_A = 8'h10;
	localparam logic [7:0] REG_PE_A = 8'h13;
	localparam int SEL_LSB = 0;
	localparam int BICAST_BIT = 2;
	localparam int LOOP_LSB = 4;
	localparam int STAT_MODE_LSB = 4;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [3:0] EQ_MAX = 4'h9;
	localparam logic [3:0] EQ_RST = 4'h0;
	localparam logic [3:0] EQ_PIN_LO = 4'h0;
	localparam logic [3:0] EQ_PIN_HI = 4'h5;
	localparam logic [2:0] PE_RST = 3'h0;
	localparam logic [2:0] PE_PIN_LO = 3'h0;
	localparam logic [2:0] PE_PIN_HI = 3'h4;
	typedef enum logic [1:0] {
		MODE_PIN = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_MIXED = 2'h2,
		MODE_SERIAL = 2'h3
	} scm_mode_t;
	typedef enum logic [1:0] {
		SRC_IDLE = 2'h0,
		SRC_A = 2'h1,
		SRC_B = 2'h2,
		SRC_C = 2'h3
	} scm_src_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h3,
		ST_PTR = 4'h2,
		ST_PTR_ACK = 4'h6,
		ST_WDATA = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA = 4'h4,
		ST_RDATA_ACK = 4'hc
	} scm_i2c_state_t;
	typedef struct packed {
		logic rst_n;
		logic bicast;
		logic [NUM_LANES-1:0] sel;
		logic [NUM_PORTS-1:0] loop;
		logic [NUM_PORTS-1:0] eq;
		logic [NUM_PORTS-1:0] pe;
		logic [NUM_PORTS-1:0] los;
	} scm_pins_t;
endpackage : scm_pkg

// >>> pkg/scm_reg_if.sv
// Register request/answer carrier between the I2C link and the register file
`timescale 1ns/10ps
interface scm_reg_if;
	logic req_tog;
	logic is_wr;
	logic [7:0] ptr;
	logic [7:0] wdata;
	logic ack_tog;
	logic [7:0] rdata;
	modport link (output req_tog, output is_wr, output ptr, output wdata,
		input ack_tog, input rdata);
	modport regs (input req_tog, input is_wr, input ptr, input wdata,
		output ack_tog, output rdata);
endinterface : scm_reg_if

// >>> test/scm_i2c_master.sv
// I2C master model: makes SCL and shares the pulled-up SDA with the device
`timescale 1ns/10ps
module scm_i2c_master (
	output logic scl,
	output logic sda,
	input logic dev_oe
);
	logic pull_low;
	// Released line floats to the pull-up level
	assign sda = !(pull_low || dev_oe);
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	task automatic clk_bit(input logic b, output logic r);
		pull_low = !b;
		#12;
		scl = 1'b1;
		#12;
		r = sda;
		#12;
		scl = 1'b0;
		#12;
	endtask : clk_bit
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
	endtask : xfer
	task automatic start();
		// Off the system clock grid, so the two domains never share an edge
		#1.3;
		pull_low = 1'b0;
		#12;
		scl = 1'b1;
		#12;
		pull_low = 1'b1;
		#12;
		scl = 1'b0;
		#12;
	endtask : start
	// SCL stays high between frames
	task automatic stop();
		pull_low = 1'b1;
		#12;
		scl = 1'b1;
		#12;
		pull_low = 1'b0;
		#24;
	endtask : stop
	// SCL pulses with SDA released: no START, just edges for the link's reset
	task automatic idle_clocks(input int n);
		pull_low = 1'b0;
		repeat (n) begin
			#12;
			scl = 1'b0;
			#24;
			scl = 1'b1;
			#12;
		end
	endtask : idle_clocks
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
		output logic ok);
		logic [8:0] q0, q1, q2;
		start();
		xfer({dev, 1'b0, 1'b1}, q0);
		xfer({ptr, 1'b1}, q1);
		xfer({d, 1'b1}, q2);
		stop();
		ok = !q0[0] && !q1[0] && !q2[0];
	endtask : write_reg
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
		logic [8:0] q;
		start();
		xfer({dev, 1'b0, 1'b1}, q);
		xfer({ptr, 1'b1}, q);
		start();
		xfer({dev, 1'b1, 1'b1}, q);
		xfer(9'h1ff, q);
		stop();
		d = q[8:1];
	endtask : read_reg
endmodule : scm_i2c_master

// >>> test/scm_switch_ctrl_assertions.sv
// Concurrent checks on the ports of the switch control-source block
`timescale 1ns/10ps
module scm_switch_ctrl_assertions import scm_pkg::*; (
	input logic sys_clk,
	input logic reset,
	input logic reset_pin_n,
	input logic bicast_pin,
	input logic lane0_path_select,
	input logic lane1_path_select,
	input logic port_a_loop_pin,
	input logic port_b_loop_pin,
	input logic port_c_loop_pin,
	input logic port_a_rx_boost_pin,
	input logic port_c_tx_emphasis_pin,
	input logic [NUM_PORTS-1:0] los_detect,
	input logic [1:0] active_mode,
	input logic bicast_en,
	input logic [NUM_LANES-1:0] lane_sel,
	input logic [NUM_PORTS-1:0] loop_en,
	input logic [NUM_PORTS-1:0][3:0] rx_eq_level,
	input logic [NUM_PORTS-1:0][2:0] tx_pe_level,
	input logic [NUM_LANES-1:0][1:0] port_a_src,
	input logic [NUM_LANES-1:0][1:0] port_b_src,
	input logic [NUM_LANES-1:0][1:0] port_c_src,
	input logic signal_lost_irq
);
	logic [2:0] up_reg, up_next;
	logic warm;
	logic [5:0] sw_pins;
	// Pin pipeline is three flops deep, so wait it out after reset
	always_comb begin
		up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			up_reg <= 3'h0;
		else
			up_reg <= up_next;
	end
	assign warm = (up_reg == 3'h7);
	assign sw_pins = {bicast_pin, lane1_path_select, lane0_path_select, port_c_loop_pin,
		port_b_loop_pin, port_a_loop_pin};
	function automatic logic [1:0] side_src(input logic lp, input logic [1:0] own, input logic on);
		return lp ? own : (on ? SRC_C : SRC_IDLE);
	endfunction : side_src
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	chk_mode_code: assert property (active_mode != MODE_UNDEF)
		else $error("undefined mode code shown");
	chk_pin_eq: assert property (warm && active_mode == MODE_PIN
		&& $past(active_mode) == MODE_PIN
		|-> rx_eq_level[PORT_A] == ($past(port_a_rx_boost_pin, 3) ? EQ_PIN_HI : EQ_PIN_LO))
		else $error("pin equalizer level wrong");
	chk_pin_pe: assert property (warm && active_mode == MODE_PIN
		&& $past(active_mode) == MODE_PIN
		|-> tx_pe_level[PORT_C] == ($past(port_c_tx_emphasis_pin, 3) ? PE_PIN_HI : PE_PIN_LO))
		else $error("pin emphasis level wrong");
	chk_switch_pins: assert property (warm && active_mode != MODE_SERIAL
		&& $past(active_mode) != MODE_SERIAL |-> {bicast_en, lane_sel, loop_en} == $past(sw_pins, 3))
		else $error("switch settings not from pins");
	chk_irq_quiet: assert property ((los_detect == 3'h0)[*5] |-> !signal_lost_irq)
		else $error("loss interrupt without loss");
	chk_route_c: assert property (warm |->
		port_c_src[0] == (loop_en[PORT_C] ? SRC_C : (lane_sel[0] ? SRC_B : SRC_A))
		&& port_c_src[1] == (loop_en[PORT_C] ? SRC_C : (lane_sel[1] ? SRC_B : SRC_A)))
		else $error("port C source wrong");
	chk_route_a: assert property (warm |->
		port_a_src[0] == side_src(loop_en[PORT_A], SRC_A, bicast_en || !lane_sel[0])
		&& port_a_src[1] == side_src(loop_en[PORT_A], SRC_A, bicast_en || !lane_sel[1]))
		else $error("port A source wrong");
	chk_route_b: assert property (warm |->
		port_b_src[0] == side_src(loop_en[PORT_B], SRC_B, bicast_en || lane_sel[0])
		&& port_b_src[1] == side_src(loop_en[PORT_B], SRC_B, bicast_en || lane_sel[1]))
		else $error("port B source wrong");
	chk_reset_pin: assert property ((!reset_pin_n)[*6] |-> active_mode == MODE_PIN)
		else $error("reset pin left mode set");
endmodule : scm_switch_ctrl_assertions

bind scm_switch_ctrl scm_switch_ctrl_assertions scm_switch_ctrl_assertions_i (
	.sys_clk, .reset, .reset_pin_n, .bicast_pin, .lane0_path_select, .lane1_path_select,
	.port_a_loop_pin, .port_b_loop_pin, .port_c_loop_pin, .port_a_rx_boost_pin,
	.port_c_tx_emphasis_pin, .los_detect, .active_mode, .bicast_en, .lane_sel, .loop_en,
	.rx_eq_level, .tx_pe_level, .port_a_src, .port_b_src, .port_c_src, .signal_lost_irq
);

// >>> test/scm_switch_ctrl_tb_top.sv
// Self-checking bench for pin, mixed and serial control of the switch block
`timescale 1ns/10ps
module scm_switch_ctrl_tb_top import scm_pkg::*;;
	localparam logic [7:0] MODE_WR [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
	logic sys_clk, reset, scl_clk, sda_in, sda_oe, reset_pin_n, bicast_en, irq, ok;
	logic [11:0] pins;
	logic [2:0] addr_pin, los, loop_en;
	logic [1:0] mode, lane_sel, em;
	logic [2:0][3:0] eq;
	logic [2:0][2:0] pe;
	logic [1:0][1:0] a_src, b_src, c_src;
	logic [6:0] dev;
	logic [7:0] q;
	int error_cnt, n_checks, cycles;
	scm_i2c_master scm_i2c_master_i (.scl(scl_clk), .sda(sda_in), .dev_oe(sda_oe));
	scm_switch_ctrl scm_switch_ctrl_i (
		.sys_clk, .reset, .scl_clk, .sda_in, .sda_out(), .sda_oe,
		.i2c_addr_pin(addr_pin), .reset_pin_n, .bicast_pin(pins[11]),
		.lane1_path_select(pins[10]), .lane0_path_select(pins[9]),
		.port_c_loop_pin(pins[8]), .port_b_loop_pin(pins[7]), .port_a_loop_pin(pins[6]),
		.port_c_rx_boost_pin(pins[5]), .port_b_rx_boost_pin(pins[4]),
		.port_a_rx_boost_pin(pins[3]), .port_c_tx_emphasis_pin(pins[2]),
		.port_b_tx_emphasis_pin(pins[1]), .port_a_tx_emphasis_pin(pins[0]),
		.los_detect(los), .active_mode(mode), .bicast_en, .lane_sel, .loop_en,
		.rx_eq_level(eq), .tx_pe_level(pe), .port_a_src(a_src), .port_b_src(b_src),
		.port_c_src(c_src), .signal_lost_irq(irq)
	);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = !sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : settle
	task automatic set_pins(input logic [11:0] p);
		@(negedge sys_clk);
		pins = p;
		settle(5);
	endtask : set_pins
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		scm_i2c_master_i.write_reg(dev, ptr, d, ok);
		chk({7'h0, ok}, 8'h01);
		settle(8);
	endtask : wr
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		scm_i2c_master_i.read_reg(dev, ptr, q);
		chk(q, exp);
	endtask : rd
	task automatic t_pin();
		chk({6'h0, mode}, 8'h00);
		set_pins(12'haab);
		chk({2'h0, bicast_en, lane_sel, loop_en}, 8'h2a);
		chk({eq[1], eq[0]}, {EQ_PIN_LO, EQ_PIN_HI});
		chk({2'h0, pe[1], pe[2]}, {2'h0, PE_PIN_HI, PE_PIN_LO});
		chk({b_src, c_src}, {SRC_B, SRC_B, SRC_A, SRC_B});
		chk({4'h0, a_src}, {4'h0, SRC_C, SRC_C});
		$display("t_pin done");
	endtask : t_pin
	task automatic t_mode();
		for (int i = 0; i < 4; i++) begin
			em = (MODE_WR[i][1:0] == 2'h1) ? 2'h0 : MODE_WR[i][1:0];
			wr(REG_MODE, MODE_WR[i]);
			rd(REG_MODE, MODE_WR[i] & 8'h03);
			chk({6'h0, mode}, {6'h0, em});
		end
		$display("t_mode done");
	endtask : t_mode
	task automatic t_addr();
		@(negedge sys_clk);
		addr_pin = 3'h2;
		scm_i2c_master_i.write_reg({I2C_ADDR_HI, 3'h5}, REG_MODE, 8'h03, ok);
		chk({7'h0, ok}, 8'h00);
		scm_i2c_master_i.write_reg({4'h5, 3'h2}, REG_MODE, 8'h03, ok);
		chk({7'h0, ok}, 8'h00);
		dev = {I2C_ADDR_HI, 3'h2};
		rd(REG_MODE, 8'h00);
		rd(8'h20, RD_UNMAPPED);
		$display("t_addr done");
	endtask : t_addr
	task automatic t_mixed();
		wr(REG_MODE, 8'h02);
		wr(REG_EQ_A, 8'h0c);
		wr(REG_PE_A + 8'h02, 8'h06);
		set_pins(12'h608);
		chk({2'h0, bicast_en, lane_sel, loop_en}, 8'h18);
		chk({4'h0, eq[0]}, {4'h0, EQ_MAX});
		chk({5'h0, pe[2]}, 8'h06);
		rd(REG_EQ_A, {4'h0, EQ_MAX});
		$display("t_mixed done");
	endtask : t_mixed
	task automatic t_serial();
		wr(REG_MODE, 8'h03);
		wr(REG_SWITCH, 8'h51);
		set_pins(12'hfff);
		chk({2'h0, bicast_en, lane_sel, loop_en}, 8'h0d);
		chk({4'h0, eq[0]}, {4'h0, EQ_MAX});
		chk({a_src, c_src}, {SRC_A, SRC_A, SRC_C, SRC_C});
		$display("t_serial done");
	endtask : t_serial
	task automatic t_reset_pin();
		@(negedge sys_clk);
		reset_pin_n = 1'b0;
		settle(8);
		reset_pin_n = 1'b1;
		settle(5);
		chk({6'h0, mode}, 8'h00);
		chk({4'h0, eq[0]}, {4'h0, EQ_PIN_HI});
		rd(REG_EQ_A, 8'h00);
		$display("t_reset_pin done");
	endtask : t_reset_pin
	task automatic t_irq();
		@(negedge sys_clk);
		los = 3'h4;
		settle(6);
		chk({7'h0, irq}, 8'h00);
		wr(REG_LOS_CFG, 8'h01);
		chk({7'h0, irq}, 8'h01);
		rd(REG_STATUS, 8'h04);
		@(negedge sys_clk);
		los = 3'h0;
		settle(6);
		chk({7'h0, irq}, 8'h00);
		$display("t_irq done");
	endtask : t_irq
	initial begin
		reset = 1'b1;
		reset_pin_n = 1'b1;
		pins = 12'h000;
		los = 3'h0;
		addr_pin = 3'h5;
		dev = {I2C_ADDR_HI, 3'h5};
		repeat (3) @(posedge sys_clk);
		// The link only sees reset on SCL edges, so clock it idle across release
		scm_i2c_master_i.idle_clocks(3);
		@(negedge sys_clk);
		reset = 1'b0;
		scm_i2c_master_i.idle_clocks(3);
		settle(6);
		t_pin();
		t_mode();
		t_addr();
		t_mixed();
		t_serial();
		t_reset_pin();
		t_irq();
		print_verdict();
	end
endmodule : scm_switch_ctrl_tb_top
